/* File: tb/cafm_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cafm_engine_model (
   // request from bench
   input wire logic hclk,
   input wire logic send,
   input wire logic [15:0] id,
   // towards the filters
   output cafm_pkg::cafm_rx_t rx
);
   // id is scrambled outside its pulse so a stale value cannot pass for a live one
   always_ff @(posedge hclk) begin
      rx.valid <= send;
      rx.ext_id <= send ? id : ~rx.ext_id;
   end
endmodule
`default_nettype wire

/* File: tb/cafm_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cafm_top_monitor (
   // watched ports
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire cafm_pkg::cafm_rx_t rx,
   input wire cafm_pkg::cafm_match_t match
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_taken;
      rx.valid ##1 match.valid;
   endsequence
   a_match_follows: assert property (rx.valid |-> s_taken) else $error("match pulse missing");
   a_match_quiet: assert property (!rx.valid |=> !match.valid) else $error("spurious match pulse");
   a_hit_holds: assert property (!rx.valid |=> $stable(match.hit)) else $error("hit moved without id");
   a_ready_after_reset: assert property ($past(hresetn) |-> hreadyout) else $error("ready low");
   a_okay_only: assert property (hreadyout |-> !hresp) else $error("error response");
   a_match_cause: assert property (match.valid |-> $past(rx.valid)) else $error("match without id");
endmodule
bind cafm_top cafm_top_monitor u_cafm_top_monitor(.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hresp(hresp), .rx(rx), .match(match));
`default_nettype wire

/* File: tb/cafm_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cafm_top_tb_top;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, send = 0, hreadyout, hresp;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [15:0] id = 16'h0000;
   logic [15:0] ids [6] = '{16'h1234, 16'h12CB, 16'h1235, 16'h1230, 16'h1204, 16'h5634};
   logic [15:0] exps [6] = '{16'hFFFF, 16'h0002, 16'h0002, 16'h0002, 16'h0006, 16'h0071};
   cafm_pkg::cafm_masks_t masks = '0;
   cafm_pkg::cafm_rx_t rx;
   cafm_pkg::cafm_match_t match;
   int n_errors = 0, n_tests = 0;
   always #4 hclk = ~hclk;
   cafm_top u_cafm_top(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rx(rx), .masks(masks), .match(match));
   cafm_engine_model u_cafm_engine_model(.hclk(hclk), .send(send), .id(id), .rx(rx));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, exp);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= cafm_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      if (!w) chk("hrdata", hrdata, exp);
   endtask
   task automatic frame(input logic [15:0] i, exp);
      send <= 1'b1;
      id <= i;
      @(posedge hclk);
      send <= 1'b0;
      @(posedge hclk);
      #1;
      chk("match", {15'h0, match.hit, match.valid}, {15'h0, exp, 1'b1});
      @(posedge hclk);
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      bus(1'b0, 8'h3C, 32'h0, 32'h0);
      bus(1'b0, cafm_pkg::OFS_MASK_SRC_LOW, 32'h0, 32'h0);
      for (int n = 0; n < 16; n++) bus(1'b1, 8'(4 * n), 32'hFFFFA500 + n, 32'h0);
      for (int n = 0; n < 16; n++) bus(1'b0, 8'(4 * n), 32'h0, 32'h0000A500 + n);
      for (int n = 0; n < 16; n++) bus(1'b1, 8'(4 * n), 32'h00001234, 32'h0);
      bus(1'b1, cafm_pkg::OFS_MASK_SRC_LOW, 32'h0000C0E4, 32'h0);
      bus(1'b0, cafm_pkg::OFS_MASK_SRC_LOW, 32'h0, 32'h0000C0E4);
      bus(1'b0, 8'h80, 32'h0, 32'h0);
      masks <= '{set2: 16'h0F0F, set1: 16'hFF00, set0: 16'h00FF};
      @(posedge hclk);
      for (int k = 0; k < 6; k++) frame(ids[k], exps[k]);
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: verilog/cafm_filter_cmp.sv */
`timescale 1ns/1ps
`default_nettype none
module cafm_filter_cmp #(
   parameter int ID_W = 16,
   parameter bit HAS_SEL = 1'b1
) (
   // filter setup
   input wire logic [ID_W-1:0] ext_id_compare_bits,
   input wire logic [1:0] mask_source,
   // compare inputs
   input wire cafm_pkg::cafm_masks_t masks,
   input wire logic [ID_W-1:0] rx_ext_id,
   // result
   output logic hit
);
   logic [ID_W-1:0] care;

   always_comb begin
      care = {ID_W{1'b1}};
      if (HAS_SEL) begin
         case (mask_source)
            cafm_pkg::MSRC_SET0: begin
               care = masks.set0;
            end
            cafm_pkg::MSRC_SET1: begin
               care = masks.set1;
            end
            cafm_pkg::MSRC_SET2: begin
               care = masks.set2;
            end
            default: begin
               // reserved: no mask, every bit is compared
               care = {ID_W{1'b1}};
            end
         endcase
      end
      // in each bit with care set, a set compare bit needs a one, a clear bit needs a zero; bits with care clear are ignored
      hit = ~|((rx_ext_id ^ ext_id_compare_bits) & care);
   end
endmodule
`default_nettype wire

/* File: verilog/cafm_pkg.sv */
package cafm_pkg;

   localparam int NUM_FILTERS = 16;
   localparam int NUM_SEL_FILTERS = 8;
   localparam int ID_W = 16;
   localparam int SEL_W = 2;
   localparam int DATA_W = 32;

   // byte addresses of the register words
   localparam logic [7:0] OFS_CMP_BASE = 8'h00;
   localparam logic [7:0] OFS_MASK_SRC_LOW = 8'h40;
   localparam logic [7:0] OFS_MATCH_STATUS = 8'h44;
   localparam logic [7:0] OFS_LAST_ID = 8'h48;

   localparam logic [5:0] IDX_MASK_SRC_LOW = 6'h10;
   localparam logic [5:0] IDX_MATCH_STATUS = 6'h11;
   localparam logic [5:0] IDX_LAST_ID = 6'h12;

   localparam logic [15:0] CMP_RESET = 16'h0000;
   localparam logic [15:0] MASK_SRC_RESET = 16'h0000;

   // mask source encoding, shared by every filter field
   localparam logic [1:0] MSRC_SET0 = 2'h0;
   localparam logic [1:0] MSRC_SET1 = 2'h1;
   localparam logic [1:0] MSRC_SET2 = 2'h2;
   localparam logic [1:0] MSRC_RESERVED = 2'h3;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

   typedef struct packed {
      logic valid;
      logic [ID_W-1:0] ext_id;
   } cafm_rx_t;

   typedef struct packed {
      logic [ID_W-1:0] set2;
      logic [ID_W-1:0] set1;
      logic [ID_W-1:0] set0;
   } cafm_masks_t;

   typedef struct packed {
      logic [NUM_FILTERS-1:0] hit;
      logic valid;
   } cafm_match_t;

endpackage

/* File: verilog/cafm_top.sv */
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cafm_top (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // protocol engine side
   input wire cafm_pkg::cafm_rx_t rx,
   input wire cafm_pkg::cafm_masks_t masks,
   // match result, one pulse per received id
   output cafm_pkg::cafm_match_t match
);
   localparam int NF = cafm_pkg::NUM_FILTERS;
   localparam int IW = cafm_pkg::ID_W;

   typedef struct packed {
      logic [NF-1:0][IW-1:0] cmp;
      logic [IW-1:0] mask_src;
      logic wr_pend;
      logic [5:0] wr_idx;
      logic [31:0] rdata;
      logic [NF-1:0] hit;
      logic hit_valid;
      logic [IW-1:0] last_id;
   } cafm_state_t;

   cafm_state_t st_reg;
   cafm_state_t st_next;
   logic [NF-1:0] hit_now;
   logic addr_phase;
   logic [5:0] a_idx;
   logic addr_ok;

   genvar g;
   generate
      for (g = 0; g < NF; g++) begin : g_flt
         // only filters 0..7 have a mask source field here; the rest compare all bits
         cafm_filter_cmp #(
            .ID_W(IW),
            .HAS_SEL(g < cafm_pkg::NUM_SEL_FILTERS)
         ) u_cmp (
            .ext_id_compare_bits(st_reg.cmp[g]),
            .mask_source((g < cafm_pkg::NUM_SEL_FILTERS) ? st_reg.mask_src[2*(g%8)+:2] : 2'h3),
            .masks(masks),
            .rx_ext_id(rx.ext_id),
            .hit(hit_now[g])
         );
      end
   endgenerate

   assign a_idx = haddr[7:2];
   assign addr_ok = (haddr[31:8] == 24'h000000) && (a_idx <= cafm_pkg::IDX_LAST_ID);
   assign addr_phase = hsel && hready && (htrans == cafm_pkg::HTRANS_NONSEQ || htrans == cafm_pkg::HTRANS_SEQ);

   always_comb begin
      st_next = st_reg;
      st_next.hit_valid = 1'b0;
      // data phase of a write: store the word
      if (st_reg.wr_pend) begin
         if (st_reg.wr_idx < 6'(NF)) begin
            st_next.cmp[st_reg.wr_idx[3:0]] = hwdata[IW-1:0];
         end else if (st_reg.wr_idx == cafm_pkg::IDX_MASK_SRC_LOW) begin
            st_next.mask_src = hwdata[IW-1:0];
         end
      end
      // received id evaluated against every filter
      if (rx.valid) begin
         st_next.hit = hit_now;
         st_next.hit_valid = 1'b1;
         st_next.last_id = rx.ext_id;
      end
      st_next.wr_pend = addr_phase && hwrite && addr_ok;
      st_next.wr_idx = a_idx;
      // compare and mask source read data taken from the updated copy so a read right after a write sees it; status and last id from st_reg
      if (addr_phase && !hwrite && addr_ok) begin
         if (a_idx < 6'(NF)) begin
            st_next.rdata = {16'h0000, st_next.cmp[a_idx[3:0]]};
         end else if (a_idx == cafm_pkg::IDX_MASK_SRC_LOW) begin
            st_next.rdata = {16'h0000, st_next.mask_src};
         end else if (a_idx == cafm_pkg::IDX_MATCH_STATUS) begin
            st_next.rdata = {16'h0000, st_reg.hit};
         end else begin
            st_next.rdata = {16'h0000, st_reg.last_id};
         end
      end else if (addr_phase) begin
         st_next.rdata = 32'h00000000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // zero wait state slave, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_comb begin
      hrdata = st_reg.rdata;
      match.hit = st_reg.hit;
      match.valid = st_reg.hit_valid;
   end
endmodule
`default_nettype wire
